// File: hw/dram_opt_ctrl.sv
/*
 * dram controller options: column strobe extension, row strobe start
 * after port b grant change, refresh request routing, counter clear,
 * hardware reset and mode capture.
 * assumes all inputs synchronous to a 10 MHz clk_i; strobes active low except access_column_strobe_i,
 * row_strobe_start_o and first_extend_column_strobe_n_i (high enables extension).
 */
`timescale 1ns/1ns
`default_nettype none
module dram_opt_ctrl (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic       mode_load_strobe_n_i,
	input  wire logic [5:0] mode_word_i,
	input  wire logic       first_extend_column_strobe_n_i,
	input  wire logic       extend_column_strobe_inputs_n_i,
	input  wire logic       port_a_access_request_n_i,
	input  wire logic       port_b_access_request_n_i,
	input  wire logic       port_b_grant_i,
	input  wire logic       precharge_done_i,
	input  wire logic       access_column_strobe_i,
	input  wire logic       scrub_refresh_i,
	input  wire logic       refresh_disable_input_n_i,
	input  wire logic       external_refresh_input_n_i,
	input  wire logic       write_enable_i,
	output logic            column_strobe_n_o,
	output logic            row_strobe_start_o,
	output logic            refresh_request_output_o,
	output logic            write_enable_pin_n_o,
	output logic            in_reset_o,
	output logic [5:0]      mode_o
);
	typedef enum logic [2:0] {
		ROW_IDLE  = 3'b001,
		ROW_WAIT1 = 3'b010,
		ROW_WAIT2 = 3'b100
	} row_state_type;

	logic [4:0]  reset_count;
	logic        hw_reset;
	logic        extend_enabled;
	logic        grant_prev;
	logic        grant_change;
	row_state_type row_state;
	logic [2:0]  clear_count;
	logic        clear_pulse;
	logic        timer_request;
	logic        column_hold;
	logic [7:0]  interval_limit;
	logic [7:0]  since_clear;

	// ------------------------------------------------------------
	// hardware reset detect
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reset_count <= 5'h0;
			hw_reset <= 1'b1;
		end else if (!mode_load_strobe_n_i && !refresh_disable_input_n_i) begin
			if (reset_count == 5'(dram_opt_pkg::RESET_EDGES - 1))
				hw_reset <= 1'b1;
			else
				reset_count <= reset_count + 5'h1;
		end else begin
			reset_count <= 5'h0;
			if (!mode_load_strobe_n_i)
				hw_reset <= 1'b0;
		end
	end
	assign in_reset_o = hw_reset;

	// ------------------------------------------------------------
	// mode capture
	// ------------------------------------------------------------
	// a load during hardware reset is ignored while refresh disable is held, so a stuck
	// strobe cannot program garbage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_o <= dram_opt_pkg::MODE_RESET;
			extend_enabled <= 1'b0;
		end else if (hw_reset && !refresh_disable_input_n_i) begin
			mode_o <= dram_opt_pkg::MODE_RESET;
			extend_enabled <= 1'b0;
		end else if (!mode_load_strobe_n_i) begin
			mode_o <= mode_word_i;
			extend_enabled <= first_extend_column_strobe_n_i;
		end
	end

	// ------------------------------------------------------------
	// column strobe extension
	// ------------------------------------------------------------
	always_comb begin
		column_hold = extend_enabled && !scrub_refresh_i
			&& !extend_column_strobe_inputs_n_i
			&& port_a_access_request_n_i && port_b_access_request_n_i;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			column_strobe_n_o <= 1'b1;
		else if (access_column_strobe_i)
			column_strobe_n_o <= 1'b0;
		else if (column_hold && !column_strobe_n_o)
			column_strobe_n_o <= 1'b0;
		else
			column_strobe_n_o <= 1'b1;
	end

	// ------------------------------------------------------------
	// row strobe after grant change
	// ------------------------------------------------------------
	assign grant_change = port_b_grant_i != grant_prev;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			grant_prev <= 1'b0;
			row_state <= ROW_IDLE;
			row_strobe_start_o <= 1'b0;
		end else begin
			grant_prev <= port_b_grant_i;
			row_strobe_start_o <= 1'b0;
			case (row_state)
			ROW_IDLE: begin
				if (grant_change && precharge_done_i) begin
					if (mode_o[dram_opt_pkg::MODE_ROW_DELAY_BIT])
						row_state <= ROW_WAIT1;
					else
						row_strobe_start_o <= 1'b1;
				end
			end
			ROW_WAIT1: begin
				row_strobe_start_o <= 1'b1;
				row_state <= ROW_IDLE;
			end
			default: row_state <= ROW_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// refresh counter clear and timer
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clear_count <= 3'h0;
			clear_pulse <= 1'b0;
		end else if (refresh_disable_input_n_i && !external_refresh_input_n_i) begin
			if (clear_count == 3'(dram_opt_pkg::CLEAR_CYCLES - 1))
				clear_pulse <= 1'b1;
			else
				clear_count <= clear_count + 3'h1;
		end else begin
			clear_count <= 3'h0;
			clear_pulse <= 1'b0;
		end
	end

	assign interval_limit = 8'(dram_opt_pkg::MIN_INTERVAL_CYCLES - 1)
		+ 8'(mode_o[dram_opt_pkg::MODE_INTERVAL_LSB +: 4] >> 1)
		* 8'(dram_opt_pkg::INTERVAL_STEP_CYCLES);

	refresh_timer #(
		.CNT_W(8)
	) u_timer (
		.clk_i     (clk_i),
		.rst_n_i   (rst_n_i),
		.clear_i   (clear_pulse || hw_reset),
		.limit_i   (interval_limit),
		.enable_i  (refresh_disable_input_n_i),
		.request_o (timer_request)
	);
	assign refresh_request_output_o = timer_request;

	// ------------------------------------------------------------
	// write enable pin sharing
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			write_enable_pin_n_o <= 1'b1;
		else if (extend_enabled || mode_o[dram_opt_pkg::MODE_INTERLEAVE_BIT])
			write_enable_pin_n_o <= !timer_request;
		else
			write_enable_pin_n_o <= !write_enable_i;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_row_delay2;
		@(posedge clk_i) disable iff (!rst_n_i)
		(row_state == ROW_IDLE && grant_change && precharge_done_i
		 && mode_o[dram_opt_pkg::MODE_ROW_DELAY_BIT])
		|=> !row_strobe_start_o ##1 row_strobe_start_o;
	endproperty
	a_row_delay2: assert property (p_row_delay2) else $error("row late");
	property p_row_delay1;
		@(posedge clk_i) disable iff (!rst_n_i)
		(row_state == ROW_IDLE && grant_change && precharge_done_i
		 && !mode_o[dram_opt_pkg::MODE_ROW_DELAY_BIT]) |=> row_strobe_start_o;
	endproperty
	a_row_delay1: assert property (p_row_delay1) else $error("row 1 late");
	property p_clear;
		@(posedge clk_i) disable iff (!rst_n_i)
		(refresh_disable_input_n_i && !external_refresh_input_n_i)[*5]
		|=> clear_pulse;
	endproperty
	a_clear: assert property (p_clear) else $error("no clear");
	property p_no_early;
		@(posedge clk_i) disable iff (!rst_n_i)
		clear_pulse |=> !timer_request [*8];
	endproperty
	a_no_early: assert property (p_no_early) else $error("early req");
	property p_reset16;
		@(posedge clk_i) disable iff (!rst_n_i)
		(!mode_load_strobe_n_i && !refresh_disable_input_n_i)[*8] ##0
		(reset_count == 5'd15) |=> hw_reset;
	endproperty
	a_reset16: assert property (p_reset16) else $error("no reset");
	property p_mode_hold;
		@(posedge clk_i) disable iff (!rst_n_i)
		(mode_load_strobe_n_i && !hw_reset) |=> $stable(mode_o);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
	property p_we_route;
		@(posedge clk_i) disable iff (!rst_n_i)
		(extend_enabled || mode_o[dram_opt_pkg::MODE_INTERLEAVE_BIT])
		|=> write_enable_pin_n_o == !$past(timer_request);
	endproperty
	a_we_route: assert property (p_we_route) else $error("we route");
	property p_extend;
		@(posedge clk_i) disable iff (!rst_n_i)
		(column_hold && !column_strobe_n_o) |=> !column_strobe_n_o;
	endproperty
	a_extend: assert property (p_extend) else $error("cas dropped");
	// helper: cycles since the timer was last cleared, saturating
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			since_clear <= 8'h00;
		else if (clear_pulse || hw_reset)
			since_clear <= 8'h00;
		else if (since_clear != 8'hff)
			since_clear <= since_clear + 8'h01;
	end
	property p_min_gap;
		@(posedge clk_i) disable iff (!rst_n_i)
		timer_request
		|-> since_clear >= 8'(dram_opt_pkg::MIN_INTERVAL_CYCLES);
	endproperty
	a_min_gap: assert property (p_min_gap) else $error("gap short");
	c_delay2: cover property (@(posedge clk_i) row_state == ROW_WAIT1);
	c_clear: cover property (@(posedge clk_i) clear_pulse);
	c_ext: cover property (@(posedge clk_i) column_hold);
endmodule
`default_nettype wire

// File: hw/dram_opt_pkg.sv
/*
 * constants shared by the dram option block: timing counts, mode bit
 * positions and refresh interval table.
 * assumes a 10 MHz system clock.
 */
package dram_opt_pkg;
	localparam int CLK_PERIOD_NS        = 100;
	// hardware reset: mode load and refresh disable held this many edges
	localparam int RESET_EDGES          = 16;
	// refresh counter clear: refresh asserted, disable negated
	localparam int CLEAR_TIME_NS        = 500;
	localparam int CLEAR_CYCLES         =
		(CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// shortest refresh request spacing after a clear
	localparam int MIN_INTERVAL_NS      = 13000;
	localparam int MIN_INTERVAL_CYCLES  =
		(MIN_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INTERVAL_STEP_NS     = 125;
	localparam int INTERVAL_STEP_CYCLES =
		(INTERVAL_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W                = 8;
	// mode word field positions
	localparam int MODE_ROW_DELAY_BIT   = 0;
	localparam int MODE_INTERLEAVE_BIT  = 1;
	localparam int MODE_INTERVAL_LSB    = 2;
	localparam int MODE_W               = 6;
	localparam logic [5:0] MODE_RESET   = 6'h00;
endpackage

// File: hw/refresh_timer.sv
/*
 * refresh request interval timer with clear.
 * assumes inputs synchronous to clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module refresh_timer #(
	parameter int CNT_W = dram_opt_pkg::CNT_W
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             clear_i,
	input  wire logic [CNT_W-1:0] limit_i,
	input  wire logic             enable_i,
	output logic                  request_o
);
	// the limit reaches past 128 cycles, so a narrower counter never fires
	if (CNT_W < 8) begin : g_width_check
		$error("counter too narrow");
	end

	logic [CNT_W-1:0] count;

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
			request_o <= 1'b0;
		end else if (clear_i) begin
			count <= '0;
			request_o <= 1'b0;
		end else if (enable_i) begin
			if (count >= limit_i) begin
				count <= '0;
				request_o <= 1'b1;
			end else begin
				count <= count + 1'b1;
				request_o <= 1'b0;
			end
		end else begin
			request_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: verification/host_model.sv
/*
 * host side model: hardware reset sequence and mode load.
 * assumes the bench calls its tasks between clock edges.
 */
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input  wire logic clk_i,
	output logic      ml_n_o,
	output logic      dis_n_o,
	output logic      ext0_n_o,
	output logic [5:0] word_o
);
	initial begin
		ml_n_o = 1'b1;
		dis_n_o = 1'b1;
		ext0_n_o = 1'b0;
		word_o = 6'h00;
	end
	// two spare edges: margin over the minimum
	task automatic hw_reset();
		@(posedge clk_i) #10;
		ml_n_o = 1'b0;
		dis_n_o = 1'b0;
		repeat (dram_opt_pkg::RESET_EDGES + 2) @(posedge clk_i);
		#10;
		ml_n_o = 1'b1;
		dis_n_o = 1'b1;
	endtask
	// word and extend input scrambled after load, capture must hold
	task automatic load(input logic [5:0] w, input logic ext);
		@(posedge clk_i) #10;
		ext0_n_o = ext;
		word_o = w;
		ml_n_o = 1'b0;
		@(posedge clk_i) #10;
		ml_n_o = 1'b1;
		word_o = ~w;
		ext0_n_o = ~ext;
	endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
/*
 * self-checking bench for the dram option block.
 * assumes host_model for reset and mode load; 10 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk_i;
	logic        rst_n_i = 1'b0;
	logic        ml_n, dis_n, ext0_n, cas_n, row_st, refresh_request_output, we_pin_n, in_rst;
	logic [5:0]  word, mode;
	logic        ext_n = 1'b1, port_a_access_request_n = 1'b1, breq_n = 1'b1, grant = 1'b0;
	logic        acc = 1'b0, scrub = 1'b0, external_refresh_input_n = 1'b1, we = 1'b0;
	logic [31:0] seed = 32'h0000_0055;
	int          error_cnt, n_compared, cyc, n;
	int          expq[$];

	host_model u_host (.clk_i(clk_i), .ml_n_o(ml_n), .dis_n_o(dis_n),
		.ext0_n_o(ext0_n), .word_o(word));
	dram_opt_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.mode_load_strobe_n_i(ml_n), .mode_word_i(word),
		.first_extend_column_strobe_n_i(ext0_n),
		.extend_column_strobe_inputs_n_i(ext_n),
		.port_a_access_request_n_i(port_a_access_request_n),
		.port_b_access_request_n_i(breq_n), .port_b_grant_i(grant),
		.precharge_done_i(1'b1), .access_column_strobe_i(acc),
		.scrub_refresh_i(scrub), .refresh_disable_input_n_i(dis_n),
		.external_refresh_input_n_i(external_refresh_input_n), .write_enable_i(we),
		.column_strobe_n_o(cas_n), .row_strobe_start_o(row_st),
		.refresh_request_output_o(refresh_request_output), .write_enable_pin_n_o(we_pin_n),
		.in_reset_o(in_rst), .mode_o(mode));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
		#10;
	endtask
	task automatic summarize();
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// row strobe pulses matched against the oldest expectation
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 2000) begin
			error_cnt++;
			summarize();
		end
		if (row_st === 1'b1) begin
			if (expq.size() == 0) chk(cyc, 0);
			else chk(cyc, expq.pop_front());
		end
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		tick(12);
		rst_n_i = 1'b1;
		u_host.hw_reset();
		tick(1);
		chk(in_rst, 1'b1);
		for (int d = 0; d < 2; d++) begin
			u_host.load({4'h0, 1'b0, d[0]}, 1'b0);
			tick(1);
			chk(in_rst, 1'b0);
			chk(mode, {4'h0, 1'b0, d[0]});
			for (int g = 0; g < 2; g++) begin
				// pulse is first seen two edges after the change, plus delay
				expq.push_back(cyc + 2 + d);
				grant = ~grant;
				tick(6);
			end
		end
		repeat (8) begin
			seed = nxt(seed);
			we = seed[4];
			tick(1);
			chk(we_pin_n, !we);
		end
		// interleave only, then extension only, with both interval ends
		for (int k = 0; k < 2; k++) begin
			u_host.load({k ? 4'hf : 4'h0, ~k[0], 1'b0}, k[0]);
			external_refresh_input_n = 1'b0;
			tick(5);
			external_refresh_input_n = 1'b1;
			n = 0;
			while (refresh_request_output !== 1'b1 && n < 300) begin
				seed = nxt(seed);
				we = seed[3];
				tick(1);
				n++;
				chk(we_pin_n, 1'b1);
			end
			chk(n >= 130 && n <= 152, 1'b1);
			tick(1);
			chk(we_pin_n, 1'b0);
		end
		// extension on, on with scrub, then off
		for (int k = 0; k < 3; k++) begin
			if (k == 2) u_host.load(6'h00, 1'b0);
			scrub = (k == 1);
			acc = 1'b1;
			port_a_access_request_n = (k == 1);
			breq_n = (k != 1);
			ext_n = 1'b0;
			tick(2);
			chk(cas_n, 1'b0);
			acc = 1'b0;
			port_a_access_request_n = 1'b1;
			breq_n = 1'b1;
			tick(4);
			chk(cas_n, k != 0);
			ext_n = 1'b1;
			tick(2);
			chk(cas_n, 1'b1);
		end
		// mid-run hardware reset must drop a programmed mode
		u_host.load(6'h3d, 1'b1);
		tick(1);
		chk(mode, 6'h3d);
		u_host.hw_reset();
		tick(1);
		chk(in_rst, 1'b1);
		chk(mode, 6'h00);
		chk(expq.size(), 0);
		summarize();
	end
endmodule
`default_nettype wire
